// File: logic/adc_ctrl.sv
// Converter input selection, conversion sequencing and result register
//
// Added by the designer: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl
  import adc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Avalon-MM slave
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Interrupt
  output logic irq,
  // Analog front end control
  output logic [1:0] ref_select_out,
  output logic internal_ref_on,
  output logic supply_ref_on,
  output logic [2:0] pos_input,
  output logic [2:0] neg_input,
  output logic [1:0] gain,
  output logic diff_mode,
  output logic [1:0] source,
  output logic conv_start,
  // Quantizer result
  input wire logic sample_valid,
  input wire logic [9:0] sample_code
);
  typedef enum logic [1:0] {ST_IDLE, ST_SETUP, ST_CONVERT} conv_state_t;

  conv_state_t state_reg;
  logic [7:0] input_select_reg;
  logic [4:0] active_channel_reg;
  logic [1:0] active_ref_reg;
  logic [9:0] result_reg;
  logic [9:0] pend_reg;
  logic pend_valid_reg;
  logic lock_reg;
  logic done_status_reg;
  logic [0:0] irq_enable_reg;
  logic [31:0] readdata_reg;
  logic waitrequest_reg;
  logic irq_reg;
  logic conv_start_reg;
  logic [1:0] ref_out_reg;
  logic int_ref_reg;
  logic supply_ref_reg;
  logic [2:0] pos_reg;
  logic [2:0] neg_reg;
  logic [1:0] gain_reg;
  logic diff_reg;
  logic [1:0] source_reg;
  logic [31:0] rd_next;
  logic [9:0] coded;
  logic [7:0] high_byte;
  logic [7:0] low_byte;
  logic access;
  logic wr_acc;
  logic rd_acc;
  logic start_req;
  logic sample_take;

  chan_if ch ();
  assign ch.channel_select = active_channel_reg;

  chan_decode u_decode (
    .ch(ch)
  );

  result_format u_format (
    .raw_code(sample_code),
    .raw_diff(diff_reg),
    .coded(coded),
    .stored(result_reg),
    .left_adjust(input_select_reg[LEFT_ADJUST_BIT]),
    .high_byte(high_byte),
    .low_byte(low_byte)
  );

  // Bus handshake: one wait cycle, then a one-cycle acknowledge
  assign access = (read | write) & waitrequest_reg;
  assign wr_acc = write & ~waitrequest_reg;
  assign rd_acc = read & ~waitrequest_reg;
  assign start_req = wr_acc & byteenable[0] & (address == OFS_CTRL)
                     & writedata[CTRL_START_BIT];
  assign sample_take = (state_reg == ST_CONVERT) & sample_valid;

  // High by default; drops for one cycle per access
  always_ff @(posedge clk) begin
    if (rst) begin
      waitrequest_reg <= 1'b1;
    end else begin
      waitrequest_reg <= ~access;
    end
  end

  // Result bytes are formatted at read time, so an alignment change shows at once
  always_comb begin
    rd_next = 32'h0000_0000;
    case (address)
      OFS_INPUT_SELECT: rd_next[7:0] = input_select_reg;
      OFS_CTRL: rd_next[CTRL_START_BIT] = (state_reg != ST_IDLE);
      OFS_RESULT_LOW: rd_next[7:0] = low_byte;
      OFS_RESULT_HIGH: rd_next[7:0] = high_byte;
      OFS_IRQ_STATUS: rd_next[IRQ_DONE_BIT] = done_status_reg;
      OFS_IRQ_ENABLE: rd_next[IRQ_DONE_BIT] = irq_enable_reg[0];
      OFS_ACTIVE: rd_next[15:0] = {result_reg[SIGN_BIT], lock_reg, diff_reg, gain_reg,
                                   active_ref_reg, source_reg, pos_reg, neg_reg, 1'b0};
      default: rd_next = 32'h0000_0000;
    endcase
  end

  // Captured when the request is first seen; stands until the next read
  always_ff @(posedge clk) begin
    if (rst) begin
      readdata_reg <= 32'h0000_0000;
    end else if (access & read) begin
      readdata_reg <= rd_next;
    end
  end

  // Software-written input selection
  always_ff @(posedge clk) begin
    if (rst) begin
      input_select_reg <= INPUT_SELECT_RST;
    end else if (wr_acc & byteenable[0] & (address == OFS_INPUT_SELECT)) begin
      input_select_reg <= writedata[7:0];
    end
  end

  // Settings in use: track the register while idle, frozen during a conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      active_channel_reg <= INPUT_SELECT_RST[4:0];
      active_ref_reg <= INPUT_SELECT_RST[7:6];
    end else if (state_reg == ST_IDLE) begin
      active_channel_reg <= input_select_reg[4:0];
      active_ref_reg <= input_select_reg[REF_SEL_LSB+1:REF_SEL_LSB];
    end
  end

  // Conversion sequencing; a start request while busy is dropped
  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_req) begin
            state_reg <= ST_SETUP;
          end
        end
        ST_SETUP: begin
          state_reg <= ST_CONVERT;
        end
        ST_CONVERT: begin
          if (sample_valid) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Start pulse: exactly one cycle, as setup hands over to converting
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_start_reg <= 1'b0;
    end else begin
      conv_start_reg <= (state_reg == ST_SETUP);
    end
  end

  // Reference switches; the reserved code opens both so nothing is shorted to the pin
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_out_reg <= REF_EXT_PIN;
      int_ref_reg <= 1'b0;
      supply_ref_reg <= 1'b0;
    end else begin
      ref_out_reg <= active_ref_reg;
      int_ref_reg <= (active_ref_reg == REF_INTERNAL);
      supply_ref_reg <= (active_ref_reg == REF_SUPPLY);
    end
  end

  // Input routing; diff_reg also picks the coding of the running conversion
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_reg <= 3'h0;
      neg_reg <= 3'h0;
      gain_reg <= GAIN_X1;
      diff_reg <= 1'b0;
      source_reg <= SRC_PIN;
    end else begin
      pos_reg <= ch.pos_input;
      neg_reg <= ch.neg_input;
      gain_reg <= ch.gain;
      diff_reg <= ch.diff;
      source_reg <= ch.source;
    end
  end

  // Result read lock: low-byte read locks, high-byte read releases
  always_ff @(posedge clk) begin
    if (rst) begin
      lock_reg <= 1'b0;
    end else if (rd_acc & (address == OFS_RESULT_HIGH)) begin
      lock_reg <= 1'b0;
    end else if (rd_acc & (address == OFS_RESULT_LOW)) begin
      lock_reg <= 1'b1;
    end
  end

  // Result register; a result held back by the lock moves in once it is released
  always_ff @(posedge clk) begin
    if (rst) begin
      result_reg <= RESULT_RST;
    end else if (sample_take & ~lock_reg) begin
      result_reg <= coded;
    end else if (~lock_reg & pend_valid_reg) begin
      result_reg <= pend_reg;
    end
  end

  // Newest result that came in while the bytes were locked
  always_ff @(posedge clk) begin
    if (rst) begin
      pend_reg <= RESULT_RST;
      pend_valid_reg <= 1'b0;
    end else if (sample_take & lock_reg) begin
      pend_reg <= coded;
      pend_valid_reg <= 1'b1;
    end else if (~lock_reg) begin
      pend_valid_reg <= 1'b0;
    end
  end

  // Done flag: a new result wins over a clear in the same cycle
  // A result held back by the lock still raises it
  always_ff @(posedge clk) begin
    if (rst) begin
      done_status_reg <= 1'b0;
    end else if (sample_take) begin
      done_status_reg <= 1'b1;
    end else if (wr_acc & byteenable[0] & (address == OFS_IRQ_CLEAR)
                 & writedata[IRQ_DONE_BIT]) begin
      done_status_reg <= 1'b0;
    end
  end

  // Interrupt enable, same layout as the status register
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable_reg <= IRQ_ENABLE_RST;
    end else if (wr_acc & byteenable[0] & (address == OFS_IRQ_ENABLE)) begin
      irq_enable_reg <= writedata[IRQ_DONE_BIT +: 1];
    end
  end

  // Level interrupt, one cycle behind the flag and its enable
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= done_status_reg & irq_enable_reg[0];
    end
  end

  assign readdata = readdata_reg;
  assign waitrequest = waitrequest_reg;
  assign irq = irq_reg;
  assign ref_select_out = ref_out_reg;
  assign internal_ref_on = int_ref_reg;
  assign supply_ref_on = supply_ref_reg;
  assign pos_input = pos_reg;
  assign neg_input = neg_reg;
  assign gain = gain_reg;
  assign diff_mode = diff_reg;
  assign source = source_reg;
  assign conv_start = conv_start_reg;
endmodule // adc_ctrl
`default_nettype wire

// File: include/adc_pkg.sv
// Shared constants for the converter input-select and result-format logic
package adc_pkg;
  // Register byte offsets on the Avalon-MM bus
  localparam logic [4:0] OFS_INPUT_SELECT = 5'h00;
  localparam logic [4:0] OFS_CTRL = 5'h04;
  localparam logic [4:0] OFS_RESULT_LOW = 5'h08;
  localparam logic [4:0] OFS_RESULT_HIGH = 5'h0C;
  localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
  localparam logic [4:0] OFS_IRQ_CLEAR = 5'h14;
  localparam logic [4:0] OFS_IRQ_ENABLE = 5'h18;
  localparam logic [4:0] OFS_ACTIVE = 5'h1C;
  // Field positions
  localparam int REF_SEL_LSB = 6;
  localparam int LEFT_ADJUST_BIT = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int IRQ_DONE_BIT = 0;
  localparam int RES_W = 10;
  localparam int SIGN_BIT = 9;
  // Reset values
  localparam logic [7:0] INPUT_SELECT_RST = 8'h00;
  localparam logic [9:0] RESULT_RST = 10'h000;
  localparam logic [0:0] IRQ_ENABLE_RST = 1'h0;
  // Reference select codes
  localparam logic [1:0] REF_EXT_PIN = 2'h0;
  localparam logic [1:0] REF_SUPPLY = 2'h1;
  localparam logic [1:0] REF_RESERVED = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  // Gain codes towards the analog gain stage
  localparam logic [1:0] GAIN_X1 = 2'h0;
  localparam logic [1:0] GAIN_X10 = 2'h1;
  localparam logic [1:0] GAIN_X200 = 2'h2;
  // Converter source: an input pin, the bandgap or ground
  localparam logic [1:0] SRC_PIN = 2'h0;
  localparam logic [1:0] SRC_BANDGAP = 2'h1;
  localparam logic [1:0] SRC_GROUND = 2'h2;
  // Channel select groups and special codes
  localparam logic [1:0] GRP_SINGLE = 2'h0;
  localparam logic [1:0] GRP_GAIN = 2'h1;
  localparam logic [1:0] GRP_NEG1 = 2'h2;
  localparam logic [2:0] NEG_INPUT_1 = 3'h1;
  localparam logic [2:0] NEG_INPUT_2 = 3'h2;
  localparam logic [2:0] LAST_POS_NEG2 = 3'h5;
  localparam logic [2:0] SUB_BANDGAP = 3'h6;
endpackage

// File: include/chan_if.sv
// Channel-select code and its decoded analog routing
`timescale 1ns/1ps
`default_nettype none
interface chan_if;
  logic [4:0] channel_select;
  logic [2:0] pos_input;
  logic [2:0] neg_input;
  logic [1:0] gain;
  logic diff;
  logic [1:0] source;
  modport decoder (
    input channel_select,
    output pos_input, neg_input, gain, diff, source
  );
  modport user (
    output channel_select,
    input pos_input, neg_input, gain, diff, source
  );
endinterface
`default_nettype wire

// File: logic/chan_decode.sv
// Decoder from channel-select code to input pair, gain and source
`timescale 1ns/1ps
`default_nettype none
module chan_decode
  import adc_pkg::*;
(
  // Code in, routing out
  chan_if.decoder ch
);
  logic [4:0] c;
  assign c = ch.channel_select;

  always_comb begin
    ch.pos_input = c[2:0];
    ch.neg_input = 3'h0;
    ch.gain = GAIN_X1;
    ch.diff = 1'b0;
    ch.source = SRC_PIN;
    case (c[4:3])
      GRP_SINGLE: begin
        ch.pos_input = c[2:0];
      end
      GRP_GAIN: begin
        ch.diff = 1'b1;
        ch.pos_input = {1'b0, c[2], c[0]};
        ch.neg_input = {1'b0, c[2], 1'b0};
        ch.gain = c[1] ? GAIN_X200 : GAIN_X10;
      end
      GRP_NEG1: begin
        ch.diff = 1'b1;
        ch.neg_input = NEG_INPUT_1;
      end
      default: begin
        if (c[2:0] <= LAST_POS_NEG2) begin
          ch.diff = 1'b1;
          ch.neg_input = NEG_INPUT_2;
        end else begin
          ch.pos_input = 3'h0;
          ch.source = (c[2:0] == SUB_BANDGAP) ? SRC_BANDGAP : SRC_GROUND;
        end
      end
    endcase
  end
endmodule // chan_decode
`default_nettype wire

// File: logic/result_format.sv
// Result coding and byte placement
`timescale 1ns/1ps
`default_nettype none
module result_format
  import adc_pkg::*;
(
  // Raw quantizer code and the mode it was taken in
  input wire logic [9:0] raw_code,
  input wire logic raw_diff,
  output logic [9:0] coded,
  // Stored result and live alignment
  input wire logic [9:0] stored,
  input wire logic left_adjust,
  output logic [7:0] high_byte,
  output logic [7:0] low_byte
);
  // Quantizer delivers offset binary; differential results become two's complement
  assign coded = raw_diff ? {~raw_code[SIGN_BIT], raw_code[SIGN_BIT-1:0]}
                          : raw_code;

  always_comb begin
    if (left_adjust) begin
      high_byte = stored[9:2];
      low_byte = {stored[1:0], 6'h00};
    end else begin
      high_byte = {6'h00, stored[9:8]};
      low_byte = stored[7:0];
    end
  end
endmodule // result_format
`default_nettype wire

// File: testbench/adc_ctrl_monitor.sv
// Port checks for the converter control block
`timescale 1ns/1ps
`default_nettype none
module adc_ctrl_monitor
  import adc_pkg::*;
(
  // Clock, reset and bus
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic irq,
  // Front end and quantizer
  input wire logic [1:0] ref_select_out,
  input wire logic internal_ref_on,
  input wire logic supply_ref_on,
  input wire logic [2:0] pos_input,
  input wire logic [2:0] neg_input,
  input wire logic [1:0] gain,
  input wire logic diff_mode,
  input wire logic [1:0] source,
  input wire logic conv_start,
  input wire logic sample_valid,
  input wire logic [9:0] sample_code
);
  logic busy_h;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  // High from the start pulse until the quantizer answers
  always_ff @(posedge clk) begin
    if (rst || sample_valid) begin
      busy_h <= 1'b0;
    end else if (conv_start) begin
      busy_h <= 1'b1;
    end
  end
  bus_ack_a: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("no bus answer");
  reset_quiet_a: assert property (disable iff (1'b0) rst |=> readdata == 32'h0 && !irq)
    else $error("outputs active in reset");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("start pulse too long");
  start_cmd_a: assert property (write && !waitrequest && address == OFS_CTRL
    && byteenable[0] && writedata[0] && !busy_h && !conv_start |-> ##2 conv_start)
    else $error("start not issued");
  ref_decode_a: assert property (internal_ref_on == (ref_select_out == REF_INTERNAL)
    && supply_ref_on == (ref_select_out == REF_SUPPLY)) else $error("reference switch");
  single_route_a: assert property (!diff_mode |-> gain == GAIN_X1 && neg_input == 3'h0)
    else $error("single-ended route");
  gain_pair_a: assert property (gain != GAIN_X1 |-> diff_mode && !pos_input[2]
    && neg_input == {1'b0, pos_input[1], 1'b0}) else $error("gain pair");
  hold_conv_a: assert property (busy_h && !sample_valid |=> $stable({ref_select_out,
    pos_input, neg_input, gain, diff_mode, source})) else $error("settings moved");
  irq_cause_a: assert property ($rose(irq) |-> $past(sample_valid, 2) || $past(write, 2))
    else $error("irq without cause");
  cover property (conv_start);
  cover property (busy_h && sample_valid);
  cover property ($fell(irq));
endmodule // adc_ctrl_monitor
`default_nettype wire

// File: testbench/analog_src.sv
// Quantizer and analog source stand-in
`timescale 1ns/1ps
`default_nettype none
module analog_src (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Start and wanted answer
  input wire logic conv_start,
  input wire logic [7:0] lat,
  input wire logic [9:0] code,
  // Answer
  output logic sample_valid,
  output logic [9:0] sample_code
);
  initial begin
    sample_valid = 1'b0;
    sample_code = 10'h155;
  end
  // Answers after lat cycles; pairs give offset binary, after the pulse the code is inverted
  always @(posedge clk) begin
    if (!rst && conv_start) begin
      repeat (lat) @(posedge clk);
      sample_valid <= 1'b1;
      sample_code <= code;
      @(posedge clk);
      sample_valid <= 1'b0;
      sample_code <= ~code;
    end
  end
endmodule // analog_src
`default_nettype wire

// File: testbench/adc_ctrl_tb.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module adc_ctrl_tb
  import adc_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [4:0] address = 5'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [3:0] byteenable = 4'hF;
  logic [7:0] lat = 8'h03;
  logic [9:0] code = 10'h000;
  logic [31:0] seed = 32'hF692;
  logic [31:0] readdata, q;
  logic [9:0] r, sample_code;
  logic [10:0] e, m, g;
  logic waitrequest, irq, internal_ref_on, supply_ref_on, diff_mode, conv_start, sample_valid;
  logic [1:0] ref_select_out, gain, source;
  logic [2:0] pos_input, neg_input;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  adc_ctrl u_adc_ctrl (.clk(clk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .ref_select_out(ref_select_out),
    .internal_ref_on(internal_ref_on), .supply_ref_on(supply_ref_on), .pos_input(pos_input),
    .neg_input(neg_input), .gain(gain), .diff_mode(diff_mode), .source(source),
    .conv_start(conv_start), .sample_valid(sample_valid), .sample_code(sample_code));
  analog_src u_analog_src (.clk(clk), .rst(rst), .conv_start(conv_start), .lat(lat),
    .code(code), .sample_valid(sample_valid), .sample_code(sample_code));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      close_out();
    end
  end
  function automatic logic [9:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[9:0];
  endfunction
  // Expected {pos, neg, gain, diff, source} for a channel code
  function automatic logic [10:0] chan(input logic [4:0] c);
    case (c[4:3])
      2'h0: return {c[2:0], 3'h0, 2'h0, 1'b0, 2'h0};
      2'h1: return {1'b0, c[2], c[0], 1'b0, c[2], 1'b0, c[1] ? 2'h2 : 2'h1, 1'b1, 2'h0};
      2'h2: return {c[2:0], 3'h1, 2'h0, 1'b1, 2'h0};
      default: return (c[2:0] > 3'h5) ? {6'h00, 3'h0, c[0] ? 2'h2 : 2'h1}
        : {c[2:0], 3'h2, 2'h0, 1'b1, 2'h0};
    endcase
  endfunction
  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    address <= a;
    write <= w;
    read <= !w;
    writedata <= {24'h000000, d};
    do @(posedge clk); while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic conv(input logic [9:0] c);
    bus(1'b1, OFS_IRQ_CLEAR, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b0, irq)
    code = c;
    bus(1'b1, OFS_CTRL, 8'h01);
  endtask
  task automatic fin();
    do bus(1'b0, OFS_IRQ_STATUS, 8'h00); while (q[0] !== 1'b1);
  endtask
  task automatic res(input logic [9:0] x, input logic la);
    bus(1'b0, OFS_RESULT_LOW, 8'h00);
    `CHK("low", la ? {x[1:0], 6'h00} : x[7:0], q[7:0])
    bus(1'b0, OFS_RESULT_HIGH, 8'h00);
    `CHK("high", la ? x[9:2] : {6'h00, x[9:8]}, q[7:0])
  endtask
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    bus(1'b0, OFS_INPUT_SELECT, 8'h00);
    `CHK("select", 8'h00, q[7:0])
    bus(1'b0, 5'h1E, 8'h00);
    `CHK("unmapped", 32'h0, q)
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, OFS_INPUT_SELECT, {i[1:0], 6'h00});
      repeat (3) @(posedge clk);
      `CHK("ref", {i[1:0], i == 3, i == 1}, {ref_select_out, internal_ref_on, supply_ref_on})
    end
    for (int c = 0; c < 32; c++) begin
      bus(1'b1, OFS_INPUT_SELECT, {3'h0, c[4:0]});
      repeat (3) @(posedge clk);
      e = chan(c[4:0]);
      m = (e[1:0] != 2'h0) ? 11'h01F : 11'h7FF;
      g = {pos_input, neg_input, gain, diff_mode, source};
      `CHK("route", e & m, g & m)
    end
    bus(1'b1, OFS_IRQ_ENABLE, 8'h01);
    bus(1'b1, OFS_INPUT_SELECT, 8'h05);
    for (int k = 0; k < 5; k++) begin
      r = (k == 0) ? 10'h000 : (k == 1) ? 10'h3FF : rnd();
      lat = 8'(k + 1);
      conv(r);
      fin();
      `CHK("irq", 1'b1, irq)
      res(r, 1'b0);
    end
    bus(1'b1, OFS_INPUT_SELECT, 8'hED);
    conv(10'h070);
    fin();
    res(10'h270, 1'b1);
    bus(1'b1, OFS_INPUT_SELECT, 8'hCD);
    res(10'h270, 1'b0);
    for (int k = 0; k < 4; k++) begin
      r = (k == 0) ? 10'h200 : (k == 1) ? 10'h1FF : rnd();
      conv(r + 10'h200);
      fin();
      res(r, 1'b0);
    end
    // Offset measurement: same input on both sides of the pair
    bus(1'b1, OFS_INPUT_SELECT, 8'h1A);
    conv(10'h203);
    fin();
    `CHK("offset pair", 6'h12, {pos_input, neg_input})
    res(10'h003, 1'b0);
    bus(1'b1, OFS_INPUT_SELECT, 8'h01);
    conv(10'h2AB);
    fin();
    lat = 8'h28;
    conv(10'h135);
    bus(1'b1, OFS_INPUT_SELECT, 8'hF0);
    res(10'h2AB, 1'b1);
    `CHK("held", 6'h02, {ref_select_out, pos_input, diff_mode})
    fin();
    res(10'h135, 1'b1);
    repeat (3) @(posedge clk);
    `CHK("moved", 6'h31, {ref_select_out, pos_input, diff_mode})
    bus(1'b0, OFS_RESULT_LOW, 8'h00);
    lat = 8'h02;
    conv(10'h0F0);
    fin();
    bus(1'b0, OFS_RESULT_HIGH, 8'h00);
    `CHK("locked", 8'h4D, q[7:0])
    res(10'h2F0, 1'b1);
    bus(1'b1, OFS_IRQ_ENABLE, 8'h00);
    conv(10'h001);
    fin();
    `CHK("masked", 1'b0, irq)
    bus(1'b1, OFS_IRQ_ENABLE, 8'h01);
    repeat (2) @(posedge clk);
    `CHK("irq", 1'b1, irq)
    close_out();
  end
endmodule // adc_ctrl_tb
bind adc_ctrl adc_ctrl_monitor u_adc_ctrl_monitor (.clk(clk), .rst(rst), .address(address),
  .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
  .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .ref_select_out(ref_select_out),
  .internal_ref_on(internal_ref_on), .supply_ref_on(supply_ref_on), .pos_input(pos_input),
  .neg_input(neg_input), .gain(gain), .diff_mode(diff_mode), .source(source),
  .conv_start(conv_start), .sample_valid(sample_valid), .sample_code(sample_code));
`default_nettype wire
